// *** gpp_pkg.sv ***
// constants and carrier types for the four-port gpio block with pin interrupts
package gpp_pkg;
   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int          NPORTS  = 4;
   localparam int          PW      = 16;
   localparam int          PORT_C  = 0;
   localparam int          PORT_D  = 1;
   localparam int          PORT_E  = 2;
   localparam int          PORT_F  = 3;
   // pins that exist per port: C2..C3 and C10..C15 absent, D14..D15 absent (54 pins)
   localparam logic [15:0] IMPL_C  = 16'h03F3;
   localparam logic [15:0] IMPL_D  = 16'h3FFF;
   localparam logic [15:0] IMPL_E  = 16'hFFFF;
   localparam logic [15:0] IMPL_F  = 16'hFFFF;
   // pins that may be handed to a peripheral alternate function
   localparam logic [15:0] ALT_C   = 16'h0003;
   localparam logic [15:0] ALT_D   = 16'h3FFF;
   localparam logic [15:0] ALT_E   = 16'hFFFF;
   localparam logic [15:0] ALT_F   = 16'hFFFF;
   // open-drain gpio outputs on port C
   localparam int          OD_LOW  = 1;
   localparam int          OD_HIGH = 4;
   // ----------------------------------------------------------------
   // register map (byte addresses, 32-bit aligned words)
   // ----------------------------------------------------------------
   localparam logic [7:0]  PORT_STRIDE  = 8'h20;
   localparam logic [4:0]  OFF_DATA     = 5'h00;
   localparam logic [4:0]  OFF_SET      = 5'h04;
   localparam logic [4:0]  OFF_CLR      = 5'h08;
   localparam logic [4:0]  OFF_TGL      = 5'h0C;
   localparam logic [4:0]  OFF_DIR      = 5'h10;
   localparam logic [4:0]  OFF_FEN      = 5'h14;
   localparam logic [7:0]  ADR_IMSK_SET = 8'h80;
   localparam logic [7:0]  ADR_IMSK_CLR = 8'h84;
   localparam logic [7:0]  ADR_EDGE     = 8'h88;
   localparam logic [7:0]  ADR_BOTH     = 8'h8C;
   localparam logic [7:0]  ADR_ISTAT    = 8'h90;
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_OUT  = 16'h0000;
   localparam logic [15:0] RST_DIR  = 16'h0000;
   localparam logic [15:0] RST_FEN  = 16'h0000;
   localparam logic [15:0] RST_IMSK = 16'h0000;
   localparam logic [15:0] RST_EDGE = 16'h0000;
   localparam logic [15:0] RST_BOTH = 16'h0000;
   localparam logic [31:0] RST_RDAT = 32'h0000_0000;
   // ----------------------------------------------------------------
   // carrier: one port's pad drive (oe_n low while driving)
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] oe_n;
   } gpp_pad_t;
   // apb access phase tracking
   typedef enum logic [1:0] {
      GPP_IDLE = 2'b01,
      GPP_DONE = 2'b10
   } gpp_apb_st_t;
endpackage

// *** gpp_pin_irq.sv ***
// one interrupt-capable pin: level or edge detection with sticky latch
`timescale 1ns/1ps
module gpp_pin_irq
   import gpp_pkg::*;
#(
   parameter logic RST_SRC = 1'b0
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // configuration
   input  wire logic edge_sel,
   input  wire logic both_sel,
   // source and software clear
   input  wire logic src,
   input  wire logic clr,
   // latched or live request
   output logic      stat
);
   logic prev;
   logic rise;
   logic fall;
   logic event_hit;

   // previous source sample for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= RST_SRC;
      end else begin
         prev <= src;
      end
   end

   assign rise      = src & ~prev;
   assign fall      = ~src & prev;
   assign event_hit = rise | (both_sel & fall);

   // edge latched, level live
   // a fresh edge in the clearing cycle wins so no event is lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat <= 1'b0;
      end else if (edge_sel) begin
         stat <= event_hit | (stat & ~clr);
      end else begin
         stat <= src;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_level_follow: assert property (!edge_sel |=> stat == $past(src))
      else $error("level request does not follow its source");
   a_edge_hold: assert property (edge_sel && stat && !clr |=> stat)
      else $error("edge request dropped without a clear");
   a_both_fall: assert property (edge_sel && both_sel && fall |=> stat)
      else $error("falling edge missed in both-edge mode");
   a_rise_only: assert property (edge_sel && !both_sel && fall && !stat |=> !stat)
      else $error("falling edge latched in rising-only mode");
endmodule

// *** gpp_gpio.sv ***
// four-port gpio block with per-pin interrupts on port f, apb slave
`timescale 1ns/1ps
module gpp_gpio
   import gpp_pkg::*;
(
   // clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // apb slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [7:0]               paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // pins: level from the pads, drive toward the pads
   input  wire logic [NPORTS-1:0][PW-1:0] pin_in,
   output gpp_pad_t  [NPORTS-1:0]         pad,
   // peripheral alternate functions
   input  wire gpp_pad_t [NPORTS-1:0]     alt,
   output logic      [NPORTS-1:0][PW-1:0] pin_state,
   // interrupt
   output logic                          irq
);
   // ----------------------------------------------------------------
   // constant tables
   // ----------------------------------------------------------------
   localparam logic [NPORTS-1:0][PW-1:0] IMPL = {IMPL_F, IMPL_E, IMPL_D, IMPL_C};
   localparam logic [NPORTS-1:0][PW-1:0] AMAP = {ALT_F, ALT_E, ALT_D, ALT_C};

   logic [NPORTS-1:0][PW-1:0] pin_meta;
   logic [NPORTS-1:0][PW-1:0] pin_sync;
   logic [NPORTS-1:0][PW-1:0] out_q;
   logic [NPORTS-1:0][PW-1:0] dir_q;
   logic [NPORTS-1:0][PW-1:0] fen_q;
   logic [PW-1:0]             imask;
   logic [PW-1:0]             edge_q;
   logic [PW-1:0]             both_q;
   logic [PW-1:0]             istat;
   logic [PW-1:0]             irq_src;
   logic [PW-1:0]             istat_clr;
   gpp_pad_t [NPORTS-1:0]     next_pad;
   gpp_apb_st_t               st;
   logic                      acc;
   logic                      wr_en;
   logic                      port_hit;
   logic [1:0]                wr_port;
   logic [4:0]                wr_off;
   logic                      next_err;
   logic [31:0]               next_rdata;
   logic [PW-1:0]             wdat;

   // ----------------------------------------------------------------
   // apb slave: one wait state, prdata from a flop
   // ----------------------------------------------------------------
   assign acc      = psel & penable;
   assign pready   = (st == GPP_DONE);
   assign wr_en    = acc & pready & pwrite & ~pslverr;
   assign port_hit = ~paddr[7] & (paddr[4:0] <= OFF_FEN);
   assign wr_port  = paddr[6:5];
   assign wr_off   = paddr[4:0];
   assign wdat     = pwdata[PW-1:0];

   // access phase tracker; the wait state gives a clean prdata flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= GPP_IDLE;
      end else begin
         case (st)
            GPP_IDLE: st <= acc ? GPP_DONE : GPP_IDLE;
            GPP_DONE: st <= GPP_IDLE;
            default:  st <= GPP_IDLE;
         endcase
      end
   end

   // read mux and decode error
   always_comb begin
      next_rdata = RST_RDAT;
      next_err   = 1'b0;
      if (port_hit) begin
         case (wr_off)
            // inputs read the pin, outputs the latch
            OFF_DATA: next_rdata[PW-1:0] = ((pin_sync[wr_port] & ~dir_q[wr_port])
                                           | (out_q[wr_port] & dir_q[wr_port]))
                                           & IMPL[wr_port];
            OFF_SET,
            OFF_CLR,
            OFF_TGL:  next_rdata[PW-1:0] = out_q[wr_port];
            OFF_DIR:  next_rdata[PW-1:0] = dir_q[wr_port];
            OFF_FEN:  next_rdata[PW-1:0] = fen_q[wr_port];
            default:  next_err = 1'b1;
         endcase
      end else begin
         case (paddr)
            ADR_IMSK_SET,
            ADR_IMSK_CLR: next_rdata[PW-1:0] = imask;
            ADR_EDGE:     next_rdata[PW-1:0] = edge_q;
            ADR_BOTH:     next_rdata[PW-1:0] = both_q;
            ADR_ISTAT:    next_rdata[PW-1:0] = istat;
            default:      next_err = 1'b1;
         endcase
      end
   end

   // capture answer during the wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= RST_RDAT;
         pslverr <= 1'b0;
      end else if (acc && st == GPP_IDLE) begin
         prdata  <= pwrite ? RST_RDAT : next_rdata;
         pslverr <= next_err;
      end else if (!acc) begin
         pslverr <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // pin input synchroniser
   // ----------------------------------------------------------------
   // two flops before any use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   assign pin_state = pin_sync;

   // ----------------------------------------------------------------
   // per-port control registers
   // ----------------------------------------------------------------
   // six registers per port; set, clear and toggle are write-one-to-modify
   // on set, clear and toggle only bits written as one change
   // outputs cleared, all pins inputs at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= {NPORTS{RST_OUT}};
      end else if (wr_en && port_hit) begin
         case (wr_off)
            OFF_DATA: out_q[wr_port] <= wdat & IMPL[wr_port];
            OFF_SET:  out_q[wr_port] <= out_q[wr_port] | (wdat & IMPL[wr_port]);
            OFF_CLR:  out_q[wr_port] <= out_q[wr_port] & ~wdat;
            OFF_TGL:  out_q[wr_port] <= out_q[wr_port] ^ (wdat & IMPL[wr_port]);
            default:  out_q[wr_port] <= out_q[wr_port];
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= {NPORTS{RST_DIR}};
      end else if (wr_en && port_hit && wr_off == OFF_DIR) begin
         dir_q[wr_port] <= wdat & IMPL[wr_port];
      end
   end

   // peripheral enable limited by fixed map
   // map has no bits for c9..c4, so they stay gpio
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fen_q <= {NPORTS{RST_FEN}};
      end else if (wr_en && port_hit && wr_off == OFF_FEN) begin
         fen_q[wr_port] <= wdat & AMAP[wr_port];
      end
   end

   // ----------------------------------------------------------------
   // pad drive
   // ----------------------------------------------------------------
   // each pin is gpio or its peripheral, absent pins float
   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         for (int b = 0; b < PW; b++) begin
            if (!IMPL[p][b]) begin
               next_pad[p].dout[b] = 1'b0;
               next_pad[p].oe_n[b] = 1'b1;
            end else if (fen_q[p][b]) begin
               next_pad[p].dout[b] = alt[p].dout[b];
               next_pad[p].oe_n[b] = alt[p].oe_n[b];
            end else begin
               next_pad[p].dout[b] = out_q[p][b];
               next_pad[p].oe_n[b] = ~dir_q[p][b];
            end
         end
      end
      for (int k = 0; k < 2; k++) begin
         if (!fen_q[PORT_C][k == 0 ? OD_LOW : OD_HIGH]) begin
            next_pad[PORT_C].dout[k == 0 ? OD_LOW : OD_HIGH] = 1'b0;
            next_pad[PORT_C].oe_n[k == 0 ? OD_LOW : OD_HIGH] =
               ~(dir_q[PORT_C][k == 0 ? OD_LOW : OD_HIGH]
                 & ~out_q[PORT_C][k == 0 ? OD_LOW : OD_HIGH]);
         end
      end
   end

   // pad drive from flops so the pins never glitch on a decode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad <= {NPORTS{{16'h0000, 16'hFFFF}}};
      end else begin
         pad <= next_pad;
      end
   end

   // ----------------------------------------------------------------
   // port f pin interrupts
   // ----------------------------------------------------------------
   // mask set and mask clear registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask <= RST_IMSK;
      end else if (wr_en && paddr == ADR_IMSK_SET) begin
         imask <= imask | wdat;
      end else if (wr_en && paddr == ADR_IMSK_CLR) begin
         imask <= imask & ~wdat;
      end
   end

   // level or edge select; edge kind select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_q <= RST_EDGE;
         both_q <= RST_BOTH;
      end else if (wr_en && paddr == ADR_EDGE) begin
         edge_q <= wdat;
      end else if (wr_en && paddr == ADR_BOTH) begin
         both_q <= wdat;
      end
   end

   // inputs use the pin, outputs the written value
   assign irq_src   = (pin_sync[PORT_F] & ~dir_q[PORT_F]) | (out_q[PORT_F] & dir_q[PORT_F]);
   assign istat_clr = (wr_en && paddr == ADR_ISTAT) ? wdat : '0;

   // one detector per port f pin
   for (genvar g = 0; g < PW; g++) begin : g_irq
      gpp_pin_irq #(
         .RST_SRC (1'b0)
      ) u_irq (
         .pclk     (pclk),
         .presetn  (presetn),
         .edge_sel (edge_q[g]),
         .both_sel (both_q[g]),
         .src      (irq_src[g]),
         .clr      (istat_clr[g]),
         .stat     (istat[g])
      );
   end

   // level interrupt while any unmasked request stands
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(istat & imask);
      end
   end

   // ----------------------------------------------------------------
   // assertions and covers
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_set_bits: assert property (
      wr_en && port_hit && wr_port == 2'd3 && wr_off == OFF_SET
      |=> out_q[PORT_F] == ($past(out_q[PORT_F]) | $past(wdat)))
      else $error("set write did not raise exactly the chosen bits");
   a_clr_bits: assert property (
      wr_en && port_hit && wr_port == 2'd3 && wr_off == OFF_CLR
      |=> out_q[PORT_F] == ($past(out_q[PORT_F]) & ~$past(wdat)))
      else $error("clear write did not lower exactly the chosen bits");
   a_tgl_bits: assert property (
      wr_en && port_hit && wr_port == 2'd3 && wr_off == OFF_TGL
      |=> out_q[PORT_F] == ($past(out_q[PORT_F]) ^ $past(wdat)))
      else $error("toggle write did not invert exactly the chosen bits");
   a_dir_drive: assert property (
      wr_en && port_hit && wr_port == 2'd2 && wr_off == OFF_DIR && fen_q[PORT_E] == '0
      ##1 fen_q[PORT_E] == '0 |=> pad[PORT_E].oe_n == ~$past(dir_q[PORT_E]))
      else $error("port e drive does not follow its direction bits");
   a_read_pins: assert property (
      acc && !pready && !pwrite && port_hit && wr_port == 2'd3
      && wr_off == OFF_DATA && dir_q[PORT_F] == '0
      |=> prdata[PW-1:0] == $past(pin_sync[PORT_F]))
      else $error("data read does not show the input pins");
   a_c_gpio_only: assert property (fen_q[PORT_C][9:4] == 6'h00)
      else $error("gpio-only pins were given to a peripheral");
   a_open_drain: assert property (
      !fen_q[PORT_C][OD_LOW] ##1 !pad[PORT_C].oe_n[OD_LOW] |-> !pad[PORT_C].dout[OD_LOW])
      else $error("open-drain pin drove a high level");
   a_mask_set: assert property (
      wr_en && paddr == ADR_IMSK_SET |=> imask == ($past(imask) | $past(wdat)))
      else $error("mask set write did not enable the chosen pins");
   a_irq_out: assert property (
      (istat & imask) != '0 |=> irq)
      else $error("unmasked request did not raise the interrupt");
   a_irq_quiet: assert property (
      (istat & imask) == '0 |=> !irq)
      else $error("interrupt raised with no unmasked request");
   a_mask_clr: assert property (
      wr_en && paddr == ADR_IMSK_CLR |=> imask == ($past(imask) & ~$past(wdat)))
      else $error("mask clear write did not disable the chosen pins");
   a_edge_write: assert property (
      wr_en && paddr == ADR_EDGE |=> edge_q == $past(wdat))
      else $error("sensitivity write did not land");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("ready stood for more than one cycle");

   c_set_write: cover property (wr_en && port_hit && wr_off == OFF_SET);
   c_irq_rise:  cover property (!irq ##1 irq);
   c_edge_clr:  cover property (edge_q[0] && istat[0] ##1 istat_clr[0]);
   c_od_low:    cover property (!pad[PORT_C].oe_n[OD_HIGH]);
   c_err_resp:  cover property (pready && pslverr);
endmodule

// *** gpp_pin_model.sv ***
// external pin model: board pull-ups plus a far-side driver steered by the bench
`timescale 1ns/1ps
module gpp_pin_model
   import gpp_pkg::*;
(
   // drive from the block
   input  wire gpp_pad_t [NPORTS-1:0]       pad,
   // far-side driver controlled by the bench
   input  wire logic [NPORTS-1:0][PW-1:0]   ext_val,
   input  wire logic [NPORTS-1:0][PW-1:0]   ext_en,
   // resolved wire levels
   output logic      [NPORTS-1:0][PW-1:0]   pin_lvl
);
   // bonded pads per port; the rest have no pad at all
   localparam logic [NPORTS-1:0][PW-1:0] PADS = {IMPL_F, IMPL_E, IMPL_D, IMPL_C};

   // ----------------------------------------------------------------
   // wire resolution
   // ----------------------------------------------------------------
   // driven or released
   // block drive wins, then the far-side driver; a line that neither drives is pulled high so open drain reads 1
   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         for (int b = 0; b < PW; b++) begin
            if (!PADS[p][b]) begin
               // no pad behind an absent pin, its input cell is tied low
               pin_lvl[p][b] = 1'b0;
            end else if (pad[p].oe_n[b] === 1'b0) begin
               pin_lvl[p][b] = pad[p].dout[b];
            end else if (ext_en[p][b]) begin
               pin_lvl[p][b] = ext_val[p][b];
            end else begin
               pin_lvl[p][b] = 1'b1;
            end
         end
      end
   end
endmodule

// *** tb_top.sv ***
// self-checking bench for the four-port gpio block with pin interrupts
`timescale 1ns/1ps
module tb_top;
   import gpp_pkg::*;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                      pclk;
   logic                      presetn;
   logic                      psel;
   logic                      penable;
   logic                      pwrite;
   logic [7:0]                paddr;
   logic [31:0]               pwdata;
   logic [31:0]               prdata;
   logic                      pready;
   logic                      pslverr;
   logic [NPORTS-1:0][PW-1:0] pin_in;
   gpp_pad_t [NPORTS-1:0]     pad;
   gpp_pad_t [NPORTS-1:0]     alt_drv;
   logic [NPORTS-1:0][PW-1:0] pin_state;
   logic                      irq;
   logic [NPORTS-1:0][PW-1:0] ext_val;
   logic [NPORTS-1:0][PW-1:0] ext_en;
   int                        n_fail;
   int                        num_checks;

   gpp_gpio u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .pad(pad), .alt(alt_drv),
      .pin_state(pin_state), .irq(irq));
   gpp_pin_model u_pins (.pad(pad), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));

   // 100 ns clock
   always #50 pclk = ~pclk;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      num_checks++;
      if (s !== x) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   task automatic c16(input string n, input logic [15:0] s, input logic [15:0] x);
      chk(n, {16'h0000, s}, {16'h0000, x});
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   function automatic logic [7:0] pa(input int p, input logic [4:0] o);
      return PORT_STRIDE * 8'(p) + {3'b000, o};
   endfunction
   // request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, {16'h0000, d}, r, e);
   endtask
   task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(n, r, {16'h0000, x});
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset defaults
   task automatic t_reset();
      for (int p = 0; p < NPORTS; p++) begin
         rdc("dir", pa(p, OFF_DIR), RST_DIR);
         c16("oe_n", pad[p].oe_n, 16'hFFFF);
      end
      rdc("imask", ADR_IMSK_SET, RST_IMSK);
      rdc("edge", ADR_EDGE, RST_EDGE);
      rdc("both", ADR_BOTH, RST_BOTH);
      c16("irq", {15'h0000, irq}, 16'h0000);
   endtask
   task automatic t_outputs();
      wr(pa(PORT_E, OFF_DIR), 16'hFFFF);
      wr(pa(PORT_E, OFF_DATA), 16'h00FF);
      wr(pa(PORT_E, OFF_SET), 16'hF000);
      rdc("set", pa(PORT_E, OFF_SET), 16'hF0FF);
      wr(pa(PORT_E, OFF_CLR), 16'h0011);
      rdc("clear", pa(PORT_E, OFF_DATA), 16'hF0EE);
      wr(pa(PORT_E, OFF_TGL), 16'h0F0F);
      wt(3);
      c16("pad e", pad[PORT_E].dout, 16'hFFE1);
      c16("oe e", pad[PORT_E].oe_n, 16'h0000);
      ext_en[PORT_E]  <= 16'hFFFF;
      ext_val[PORT_E] <= 16'h1234;
      wr(pa(PORT_E, OFF_DIR), 16'h00FF);
      wt(4);
      rdc("mixed dir", pa(PORT_E, OFF_DATA), 16'h12E1);
   endtask
   task automatic t_inputs();
      ext_en[PORT_D]  <= 16'hFFFF;
      ext_val[PORT_D] <= 16'hA5C3;
      wt(4);
      rdc("port d", pa(PORT_D, OFF_DATA), 16'hA5C3 & IMPL_D);
      c16("pin_state", pin_state[PORT_D], 16'hA5C3 & IMPL_D);
      rdc("port c", pa(PORT_C, OFF_DATA), IMPL_C);
   endtask
   task automatic t_port_c();
      wr(pa(PORT_C, OFF_DIR), 16'h03F3);
      wr(pa(PORT_C, OFF_SET), 16'h0032);
      wt(3);
      c16("od oe", pad[PORT_C].oe_n & 16'h0032, 16'h0012);
      wr(pa(PORT_C, OFF_CLR), 16'h0012);
      wt(3);
      c16("od low", pad[PORT_C].oe_n & 16'h0012, 16'h0000);
      alt_drv[PORT_C] <= '{dout: 16'h0001, oe_n: 16'hFFDC};
      wr(pa(PORT_C, OFF_FEN), 16'hFFFF);
      rdc("fen c", pa(PORT_C, OFF_FEN), ALT_C);
      wt(3);
      c16("alt c", pad[PORT_C].dout & 16'h0023, 16'h0021);
      wr(pa(PORT_C, OFF_FEN), 16'h0000);
   endtask
   task automatic t_irq();
      ext_en[PORT_F]  <= 16'hFFFF;
      ext_val[PORT_F] <= 16'h0000;
      wr(ADR_EDGE, 16'h0003);
      wr(ADR_BOTH, 16'h0002);
      wt(4);
      wr(ADR_ISTAT, 16'hFFFF);
      wr(ADR_IMSK_SET, 16'h0007);
      rdc("mask", ADR_IMSK_CLR, 16'h0007);
      rdc("quiet", ADR_ISTAT, 16'h0000);
      ext_val[PORT_F] <= 16'h0007;
      wt(6);
      c16("irq up", {15'h0000, irq}, 16'h0001);
      rdc("f pins", pa(PORT_F, OFF_DATA), 16'h0007);
      ext_val[PORT_F] <= 16'h0000;
      wt(6);
      rdc("sticky", ADR_ISTAT, 16'h0003);
      wr(ADR_ISTAT, 16'h0001);
      rdc("w1c", ADR_ISTAT, 16'h0002);
      wr(ADR_ISTAT, 16'h0002);
      ext_val[PORT_F] <= 16'h0008;
      wt(6);
      rdc("masked", ADR_ISTAT, 16'h0008);
      c16("irq mask", {15'h0000, irq}, 16'h0000);
      wr(ADR_IMSK_CLR, 16'h0007);
      ext_val[PORT_F] <= 16'h0000;
      wr(pa(PORT_F, OFF_DIR), 16'h0010);
      wr(pa(PORT_F, OFF_SET), 16'h0010);
      wr(ADR_IMSK_SET, 16'h0010);
      wt(6);
      c16("sw irq", {15'h0000, irq}, 16'h0001);
      wr(pa(PORT_F, OFF_CLR), 16'h0010);
      wt(6);
      c16("sw off", {15'h0000, irq}, 16'h0000);
      rdc("mask", ADR_IMSK_SET, 16'h0010);
      wr(pa(PORT_F, OFF_TGL), 16'h0010);
      wt(6);
      c16("sw tgl", {15'h0000, irq}, 16'h0001);
   endtask
   task automatic t_unmapped();
      logic [31:0] r;
      logic        e;
      apb(1'b0, pa(PORT_D, 5'h18), 32'h0000_0000, r, e);
      chk("err rd", {31'h0, e}, 32'h0000_0001);
      chk("err data", r, 32'h0000_0000);
      apb(1'b1, 8'hA0, 32'h0000_FFFF, r, e);
      chk("err wr", {31'h0, e}, 32'h0000_0001);
   endtask

   // ----------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      ext_val = '0;
      ext_en = '0;
      alt_drv = {NPORTS{gpp_pad_t'({16'h0000, 16'hFFFF})}};
      n_fail = 0;
      num_checks = 0;
      wt(5);
      presetn <= 1'b1;
      t_reset();
      t_outputs();
      t_inputs();
      t_port_c();
      t_irq();
      t_unmapped();
      close_out();
   end
   // a hung handshake counts as a failure
   initial begin
      wt(5000);
      n_fail++;
      close_out();
   end
endmodule
